/* File: hw/lcp_params.svh */
`ifndef LCP_PARAMS_SVH
`define LCP_PARAMS_SVH
// Contract
// R1: Idle command registers nothing; work continues.
// R2: Deselected: ignore commands; finish running work.
// R3: Mode load from A0-A12, banks idle.
// R4: Controller waits two cycles after mode load.
// R5: Open row before any bank access.
// R6: Controller waits open-to-access delay before access.
// R7: Reopen bank only after close, period apart.
// R8: Opens to different banks cross-bank delay apart.
// R9: Controller rounds nanosecond minimums up to cycles.
// R10: Read auto close after burst, open-time respected.
// R11: First read data after read latency.
// R12: Strobe driven with data, preamble and postamble; the code drives no postamble and releases the strobe with the data.
// R13: Release data lines when burst ends.
// R14: Later read concatenates or truncates earlier read.
// R15: Accept a read on any cycle.
// R16: Burst stop truncates read, read latency.
// R17: Burst stop truncates most recent read only.
// R18: Read must finish or stop before write.
// R19: Row close may truncate a running read.
// R20: Controller waits close period after row close.
// R21: Write auto close closes row after burst.
// R22: Bit ten requests auto close; bits below column.
// R23: Close with auto close bit closes all banks.
// R24: Edge-decoded commands; stop with low CKE powers down; the code decodes it as CMD_DEEP_DOWN and takes no action, like idle.
// R25: Track bank state and timers, flag misordering.

// Clock period and minimum times, in picoseconds
`define LCP_CK_PS 50000
`define LCP_T_RCD_PS 22500
`define LCP_T_RC_PS 65000
`define LCP_T_RRD_PS 15000
`define LCP_T_RAS_MIN_PS 45000
`define LCP_T_RAS_MAX_PS 70000000
`define LCP_T_RP_PS 22500
`define LCP_MRD_CYC 2
`define LCP_CEIL(t) (((t) + `LCP_CK_PS - 1) / `LCP_CK_PS)
`define LCP_RCD_CYC `LCP_CEIL(`LCP_T_RCD_PS)
`define LCP_RC_CYC `LCP_CEIL(`LCP_T_RC_PS)
`define LCP_RRD_CYC `LCP_CEIL(`LCP_T_RRD_PS)
`define LCP_RAS_MIN_CYC `LCP_CEIL(`LCP_T_RAS_MIN_PS)
`define LCP_RAS_MAX_CYC ((`LCP_T_RAS_MAX_PS) / `LCP_CK_PS)
`define LCP_RP_CYC `LCP_CEIL(`LCP_T_RP_PS)

// Mode word fields and reset values
`define LCP_BL_LSB 0
`define LCP_LAT_LSB 4
`define LCP_MODE_RST 13'h0032
`define LCP_EXT_RST 13'h0000
`define LCP_BANK_MODE 2'h0
`define LCP_BANK_EXT 2'h2
`define LCP_AC_BIT 10

// Violation flag positions
`define LCP_V_MODE 0
`define LCP_V_GAP 1
`define LCP_V_ACCESS 2
`define LCP_V_REOPEN 3
`define LCP_V_CROSS 4
`define LCP_V_CLOSING 5
`define LCP_V_WRITE 6
`define LCP_V_OVERAGE 7

`define LCP_SNAP_W 38
`endif

/* File: hw/lcp_pkg.sv */
`include "lcp_params.svh"
package lcp_pkg;
    typedef enum logic [3:0] {
        CMD_DESELECT, CMD_IDLE, CMD_ROW_OPEN, CMD_READ, CMD_WRITE,
        CMD_BURST_STOP, CMD_ROW_CLOSE, CMD_REFRESH, CMD_MODE_LOAD, CMD_DEEP_DOWN
    } lcp_cmd_e;

    typedef struct packed {
        logic rd;
        logic stop;
        logic close;
        logic all;
        logic [1:0] bank;
        logic [9:0] col;
        logic ac;
    } lcp_stage_s;

    typedef struct packed {
        logic [3:0] open;
        logic [3:0][10:0] age;
        logic [3:0][2:0] close_age;
        logic [3:0] ac_pend;
        logic [2:0] rrd_age;
        logic [2:0] mrd_age;
        lcp_stage_s [2:0] stg;
        logic rd_active;
        logic [3:0] rd_left;
        logic [1:0] rd_bank;
        logic [9:0] rd_col;
        logic rd_ac;
        logic [3:0] wr_left;
        logic [1:0] wr_bank;
        logic wr_ac;
        logic [31:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic [12:0] mode;
        logic [12:0] ext;
        logic [7:0] viol;
    } lcp_link_s;

    typedef struct packed {
        logic [3:0] open;
        logic [12:0] mode;
        logic [12:0] ext;
        logic [7:0] viol;
    } lcp_sys_s;

    typedef struct packed {
        logic [`LCP_SNAP_W-1:0] word;
        logic req;
        logic a1;
        logic a2;
        logic a3;
        logic ack_acc;
    } lcp_cdc_link_s;

    typedef struct packed {
        logic r1;
        logic r2;
        logic r3;
        logic req_acc;
        logic [`LCP_SNAP_W-1:0] word;
        logic stb;
    } lcp_cdc_sys_s;
endpackage : lcp_pkg

/* File: hw/lcp_cdc_if.sv */
`include "lcp_params.svh"
interface lcp_cdc_if;
    logic [`LCP_SNAP_W-1:0] snd_word;
    logic snd_req;
    logic busy;
    logic [`LCP_SNAP_W-1:0] rcv_word;
    logic rcv_stb;
    modport src(output snd_word, output snd_req, input busy);
    modport dst(input rcv_word, input rcv_stb);
    modport cdc(input snd_word, input snd_req, output busy, output rcv_word, output rcv_stb);
endinterface : lcp_cdc_if

/* File: hw/lcp_cdc.sv */
module lcp_cdc
    import lcp_pkg::*;
(
    // Link side
    input wire logic link_clk_in,
    input wire logic link_rst_n_in,
    // System side
    input wire logic sys_clk_in,
    input wire logic sys_rst_n_in,
    // Word transfer
    lcp_cdc_if.cdc port_if
);
    lcp_cdc_link_s lq_q, lq_d;
    lcp_cdc_sys_s sq_q, sq_d;

    // Toggle handshake: word is held until the toggle comes back
    always_comb begin
        lq_d = lq_q;
        lq_d.a1 = sq_q.req_acc;
        lq_d.a2 = lq_q.a1;
        lq_d.a3 = lq_q.a2;
        if (lq_q.a2 == lq_q.a3) begin
            lq_d.ack_acc = lq_q.a3;
        end
        if (port_if.snd_req && (lq_q.req == lq_q.ack_acc)) begin
            lq_d.word = port_if.snd_word;
            lq_d.req = ~lq_q.req;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n_in) begin
            lq_q <= '0;
        end else begin
            lq_q <= lq_d;
        end
    end

    always_comb begin
        sq_d = sq_q;
        sq_d.r1 = lq_q.req;
        sq_d.r2 = sq_q.r1;
        sq_d.r3 = sq_q.r2;
        sq_d.stb = 1'b0;
        if ((sq_q.r2 == sq_q.r3) && (sq_q.r3 != sq_q.req_acc)) begin
            sq_d.req_acc = sq_q.r3;
            sq_d.word = lq_q.word;
            sq_d.stb = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!sys_rst_n_in) begin
            sq_q <= '0;
        end else begin
            sq_q <= sq_d;
        end
    end

    assign port_if.busy = (lq_q.req != lq_q.ack_acc);
    assign port_if.rcv_word = sq_q.word;
    assign port_if.rcv_stb = sq_q.stb;

    a_word_held: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_in)
        port_if.busy |=> $stable(lq_q.word))
        else $error("snapshot word changed during handshake");
endmodule : lcp_cdc

/* File: hw/lcp_top.sv */
`include "lcp_params.svh"
module lcp_top
    import lcp_pkg::*;
(
    // System side
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] VIOL_CLEAR_IN,
    output logic [3:0] BANK_OPEN_OUT,
    output logic [12:0] MODE_REG_OUT,
    output logic [12:0] EXT_MODE_OUT,
    output logic [7:0] VIOL_OUT,
    // Link command
    input wire logic LINK_CK_IN,
    input wire logic CKE_IN,
    input wire logic CS_N_IN,
    input wire logic RAS_N_IN,
    input wire logic CAS_N_IN,
    input wire logic WE_N_IN,
    input wire logic [1:0] BANK_SEL_IN,
    input wire logic [12:0] ADDR_IN,
    // Link data
    input wire logic [31:0] DQ_IN,
    output logic [31:0] DQ_OUT,
    output logic DQ_OE_OUT,
    input wire logic DQS_IN,
    output logic DQS_OUT,
    output logic DQS_OE_OUT
);
    localparam logic [10:0] RCD_CYC = 11'(`LCP_RCD_CYC);
    localparam logic [10:0] RC_CYC = 11'(`LCP_RC_CYC);
    localparam logic [10:0] RAS_MIN_CYC = 11'(`LCP_RAS_MIN_CYC);
    localparam logic [10:0] RAS_MAX_CYC = 11'(`LCP_RAS_MAX_CYC);
    localparam logic [2:0] RRD_CYC = 3'(`LCP_RRD_CYC);
    localparam logic [2:0] RP_CYC = 3'(`LCP_RP_CYC);
    localparam logic [2:0] MRD_CYC = 3'(`LCP_MRD_CYC);

    function automatic lcp_cmd_e f_decode(input logic cke, input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
        lcp_cmd_e c;
        c = CMD_IDLE;
        if (cs_n) begin
            c = CMD_DESELECT;
        end else begin
            unique case ({ras_n, cas_n, we_n})
                3'b111: c = CMD_IDLE;
                3'b011: c = CMD_ROW_OPEN;
                3'b101: c = CMD_READ;
                3'b100: c = CMD_WRITE;
                3'b110: c = cke ? CMD_BURST_STOP : CMD_DEEP_DOWN;
                3'b010: c = CMD_ROW_CLOSE;
                3'b001: c = CMD_REFRESH;
                3'b000: c = CMD_MODE_LOAD;
            endcase
        end
        return c;
    endfunction : f_decode

    function automatic logic [1:0] f_latency(input logic [12:0] mode);
        return (mode[`LCP_LAT_LSB +: 3] == 3'h2) ? 2'h2 : 2'h3;
    endfunction : f_latency

    function automatic logic [3:0] f_pairs(input logic [12:0] mode);
        logic [3:0] p;
        unique case (mode[`LCP_BL_LSB +: 3])
            3'h1: p = 4'h1;
            3'h3: p = 4'h4;
            3'h4: p = 4'h8;
            default: p = 4'h2;
        endcase
        return p;
    endfunction : f_pairs

    // Array stand-in: each element carries its own bank and column
    function automatic logic [31:0] f_pair(input logic [1:0] bank, input logic [9:0] col);
        logic [9:0] col_b;
        col_b = col + 10'h001;
        return {bank, 4'h0, col_b, bank, 4'h0, col};
    endfunction : f_pair

    // Link reset crossing; these flops cannot reset themselves
    logic lrs1_q, lrs2_q, lrs3_q, lrst_n_q;
    always_ff @(posedge LINK_CK_IN) begin
        lrs1_q <= RST_N_IN;
        lrs2_q <= lrs1_q;
        lrs3_q <= lrs2_q;
        if (lrs2_q == lrs3_q) begin
            lrst_n_q <= lrs3_q;
        end
    end

    lcp_link_s lq_q, lq_d;
    lcp_sys_s sq_q, sq_d;
    lcp_cmd_e cmd;
    lcp_stage_s tap, pre;
    logic [1:0] lat;
    logic [3:0] pairs;
    logic [9:0] cmask;
    logic [7:0] nv;
    logic [7:0] rx_viol;
    logic access_bad;

    lcp_cdc_if cdc_bus();

    lcp_cdc u_cdc (
        .link_clk_in(LINK_CK_IN),
        .link_rst_n_in(lrst_n_q),
        .sys_clk_in(SYS_CLK_IN),
        .sys_rst_n_in(RST_N_IN),
        .port_if(cdc_bus.cdc)
    );

    always_comb begin
        lq_d = lq_q;
        nv = 8'h00;
        cmd = f_decode(CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN); // R24
        lat = f_latency(lq_q.mode);
        pairs = f_pairs(lq_q.mode);
        cmask = 10'({pairs, 1'b0} - 5'h01);
        tap = lq_q.stg[lat - 2'h1];
        pre = lq_q.stg[lat - 2'h2];
        access_bad = !lq_q.open[BANK_SEL_IN] || (lq_q.age[BANK_SEL_IN] < RCD_CYC);

        // Bank timers and deferred auto close
        for (int b = 0; b < 4; b++) begin
            if (lq_q.age[b] != 11'h7FF) begin
                lq_d.age[b] = lq_q.age[b] + 11'h001;
            end
            if (lq_q.close_age[b] != 3'h7) begin
                lq_d.close_age[b] = lq_q.close_age[b] + 3'h1;
            end
            if (lq_q.open[b] && (lq_q.age[b] == RAS_MAX_CYC)) begin
                nv[`LCP_V_OVERAGE] = 1'b1; // R10
            end
            if (lq_q.ac_pend[b] && (lq_q.age[b] >= RAS_MIN_CYC)) begin
                lq_d.open[b] = 1'b0; // R10
                lq_d.ac_pend[b] = 1'b0;
                lq_d.close_age[b] = 3'h1;
            end
        end
        if (lq_q.rrd_age != 3'h7) begin
            lq_d.rrd_age = lq_q.rrd_age + 3'h1;
        end
        if (lq_q.mrd_age != 3'h7) begin
            lq_d.mrd_age = lq_q.mrd_age + 3'h1;
        end

        // Latency line: a command reaches the tap one cycle short of the read latency
        lq_d.stg[2] = lq_q.stg[1];
        lq_d.stg[1] = lq_q.stg[0];
        lq_d.stg[0] = '0;

        // Read data engine
        lq_d.dq_oe = 1'b0;
        lq_d.dqs_oe = 1'b0;
        lq_d.dqs = 1'b0;
        if (tap.rd) begin
            lq_d.rd_active = 1'b1; // R11 R14 R15
            lq_d.rd_left = pairs - 4'h1;
            lq_d.rd_bank = tap.bank;
            lq_d.rd_col = tap.col;
            lq_d.rd_ac = tap.ac;
            lq_d.dq = f_pair(tap.bank, tap.col);
        end else if (lq_q.rd_active && (tap.stop
                     || (tap.close && (tap.all || (tap.bank == lq_q.rd_bank))))) begin
            lq_d.rd_active = 1'b0; // R16 R17 R19
        end else if (lq_q.rd_active && (lq_q.rd_left != 4'h0)) begin
            lq_d.rd_left = lq_q.rd_left - 4'h1;
            lq_d.rd_col = (lq_q.rd_col & ~cmask) | ((lq_q.rd_col + 10'h002) & cmask);
            lq_d.dq = f_pair(lq_q.rd_bank, lq_d.rd_col);
        end else if (lq_q.rd_active) begin
            lq_d.rd_active = 1'b0; // R13
            if (lq_q.rd_ac) begin
                lq_d.ac_pend[lq_q.rd_bank] = 1'b1; // R10
            end
        end
        // Strobe high for the whole cycle of each pair; it is driven low only during the preamble
        if (lq_d.rd_active) begin
            lq_d.dq_oe = 1'b1; // R12
            lq_d.dqs_oe = 1'b1;
            lq_d.dqs = 1'b1;
        end else if (pre.rd) begin
            lq_d.dqs_oe = 1'b1; // R12
        end

        // Write burst timing only; write data is not stored
        if (lq_q.wr_left != 4'h0) begin
            lq_d.wr_left = lq_q.wr_left - 4'h1;
            if ((lq_q.wr_left == 4'h1) && lq_q.wr_ac) begin
                lq_d.ac_pend[lq_q.wr_bank] = 1'b1; // R21
            end
        end

        // Misordering checks on the controller's traffic
        if (!(cmd inside {CMD_DESELECT, CMD_IDLE, CMD_DEEP_DOWN}) && (lq_q.mrd_age < MRD_CYC)) begin
            nv[`LCP_V_GAP] = 1'b1; // R4
        end
        if ((cmd inside {CMD_ROW_OPEN, CMD_READ, CMD_WRITE})
            && (lq_q.close_age[BANK_SEL_IN] < RP_CYC)) begin
            nv[`LCP_V_CLOSING] = 1'b1; // R20
        end

        unique case (cmd)
            CMD_DESELECT, CMD_IDLE, CMD_REFRESH, CMD_DEEP_DOWN: begin
            end // R1 R2 R24
            CMD_MODE_LOAD: begin
                if ((|lq_q.open) || lq_q.rd_active || (lq_q.wr_left != 4'h0)) begin
                    nv[`LCP_V_MODE] = 1'b1; // R3
                end
                if (BANK_SEL_IN == `LCP_BANK_MODE) begin
                    lq_d.mode = ADDR_IN; // R3
                end else if (BANK_SEL_IN == `LCP_BANK_EXT) begin
                    lq_d.ext = ADDR_IN;
                end
                lq_d.mrd_age = 3'h1;
            end
            CMD_ROW_OPEN: begin
                if (lq_q.open[BANK_SEL_IN] || (lq_q.age[BANK_SEL_IN] < RC_CYC)) begin
                    nv[`LCP_V_REOPEN] = 1'b1; // R7 R25
                end
                if (lq_q.rrd_age < RRD_CYC) begin
                    nv[`LCP_V_CROSS] = 1'b1; // R8
                end
                lq_d.open[BANK_SEL_IN] = 1'b1; // R5
                lq_d.age[BANK_SEL_IN] = 11'h001;
                lq_d.ac_pend[BANK_SEL_IN] = 1'b0;
                lq_d.rrd_age = 3'h1;
            end
            CMD_READ: begin
                nv[`LCP_V_ACCESS] = access_bad; // R6 R25
                lq_d.stg[0].rd = 1'b1;
                lq_d.stg[0].bank = BANK_SEL_IN;
                lq_d.stg[0].col = ADDR_IN[9:0]; // R22
                lq_d.stg[0].ac = ADDR_IN[`LCP_AC_BIT];
            end
            CMD_WRITE: begin
                nv[`LCP_V_ACCESS] = access_bad; // R5 R6
                if ((lq_q.rd_active || (|{lq_q.stg[0].rd, lq_q.stg[1].rd, lq_q.stg[2].rd}))
                    && !(|{lq_q.stg[0].stop, lq_q.stg[1].stop, lq_q.stg[2].stop})) begin
                    nv[`LCP_V_WRITE] = 1'b1; // R18
                end
                lq_d.wr_left = pairs;
                lq_d.wr_bank = BANK_SEL_IN;
                lq_d.wr_ac = ADDR_IN[`LCP_AC_BIT]; // R22
            end
            CMD_BURST_STOP: begin
                lq_d.stg[0].stop = 1'b1; // R16
            end
            CMD_ROW_CLOSE: begin
                lq_d.stg[0].close = 1'b1; // R19
                lq_d.stg[0].all = ADDR_IN[`LCP_AC_BIT];
                lq_d.stg[0].bank = BANK_SEL_IN;
                for (int b = 0; b < 4; b++) begin
                    // Closing an idle bank does nothing
                    if ((ADDR_IN[`LCP_AC_BIT] || (BANK_SEL_IN == 2'(b))) && lq_q.open[b]) begin
                        lq_d.open[b] = 1'b0; // R23
                        lq_d.close_age[b] = 3'h1;
                        lq_d.ac_pend[b] = 1'b0;
                    end
                end
            end
        endcase

        // Flags accumulate until a snapshot carries them away; new ones are kept
        lq_d.viol = (cdc_bus.busy ? lq_q.viol : 8'h00) | nv;
    end

    always_ff @(posedge LINK_CK_IN) begin
        if (!lrst_n_q) begin
            lq_q <= '0;
            lq_q.age <= '1;
            lq_q.close_age <= '1;
            lq_q.rrd_age <= '1;
            lq_q.mrd_age <= '1;
            lq_q.mode <= `LCP_MODE_RST;
            lq_q.ext <= `LCP_EXT_RST;
        end else begin
            lq_q <= lq_d;
        end
    end

    assign cdc_bus.snd_req = !cdc_bus.busy;
    assign cdc_bus.snd_word = {lq_q.open, lq_q.viol, lq_q.mode, lq_q.ext};

    // System domain view, refreshed by each snapshot
    always_comb begin
        sq_d = sq_q;
        rx_viol = 8'h00;
        if (cdc_bus.rcv_stb) begin
            sq_d.open = cdc_bus.rcv_word[37:34];
            rx_viol = cdc_bus.rcv_word[33:26];
            sq_d.mode = cdc_bus.rcv_word[25:13];
            sq_d.ext = cdc_bus.rcv_word[12:0];
        end
        sq_d.viol = (sq_q.viol & ~VIOL_CLEAR_IN) | rx_viol;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            sq_q <= '0;
            sq_q.mode <= `LCP_MODE_RST;
            sq_q.ext <= `LCP_EXT_RST;
        end else begin
            sq_q <= sq_d;
        end
    end

    assign BANK_OPEN_OUT = sq_q.open;
    assign MODE_REG_OUT = sq_q.mode;
    assign EXT_MODE_OUT = sq_q.ext;
    assign VIOL_OUT = sq_q.viol;
    assign DQ_OUT = lq_q.dq;
    assign DQ_OE_OUT = lq_q.dq_oe;
    assign DQS_OUT = lq_q.dqs;
    assign DQS_OE_OUT = lq_q.dqs_oe;

    default clocking cb @(posedge LINK_CK_IN);
    endclocking
    default disable iff (!lrst_n_q);

    a_read_lat3_data: assert property ((cmd == CMD_READ) && (lat == 2'h3) |-> // R11
        ##4 (DQ_OE_OUT && (DQ_OUT[9:0] == $past(ADDR_IN[9:0], 4))))
        else $error("read data missing at latency three");
    a_read_lat2_data: assert property ((cmd == CMD_READ) && (lat == 2'h2) |-> // R11
        ##3 (DQ_OE_OUT && (DQ_OUT[9:0] == $past(ADDR_IN[9:0], 3))))
        else $error("read data missing at latency two");
    a_read_preamble: assert property ((cmd == CMD_READ) && (lat == 2'h3) && !lq_q.rd_active // R12
        && !(|{lq_q.stg[0].rd, lq_q.stg[1].rd, lq_q.stg[2].rd})
        |-> ##3 (DQS_OE_OUT && !DQS_OUT && !DQ_OE_OUT))
        else $error("read preamble missing");
    a_burst_release: assert property (lq_q.rd_active && (lq_q.rd_left == 4'h0) // R13
        && !tap.rd && !pre.rd |=> !DQ_OE_OUT && !DQS_OE_OUT)
        else $error("data lines not released after burst");
    a_idle_no_cmd: assert property ((cmd == CMD_IDLE) |=> // R1
        (lq_q.stg[0] == '0) && $stable(lq_q.mode) && $stable(lq_q.ext))
        else $error("idle command registered something");
    a_deselect_no_cmd: assert property ((cmd == CMD_DESELECT) |=> // R2
        (lq_q.stg[0] == '0) && $stable(lq_q.mode) && (lq_q.rrd_age != 3'h1))
        else $error("deselected device took a command");
    a_mode_load: assert property ((cmd == CMD_MODE_LOAD) && (BANK_SEL_IN == `LCP_BANK_MODE) // R3
        |=> lq_q.mode == $past(ADDR_IN))
        else $error("mode word not loaded");
    a_row_open: assert property ((cmd == CMD_ROW_OPEN) |=> lq_q.open[$past(BANK_SEL_IN)]) // R5
        else $error("row open did not mark bank open");
    a_close_all: assert property ((cmd == CMD_ROW_CLOSE) && ADDR_IN[`LCP_AC_BIT] // R23
        |=> lq_q.open == 4'h0)
        else $error("close all left a bank open");
    a_stop_truncates: assert property (lq_q.rd_active && tap.stop |=> !DQ_OE_OUT) // R16
        else $error("burst stop did not truncate read");
    a_deep_down: assert property (!CKE_IN && !CS_N_IN && RAS_N_IN && CAS_N_IN && !WE_N_IN // R24
        |=> !lq_q.stg[0].stop)
        else $error("deep power-down taken as burst stop");
    a_write_autoclose: assert property ((cmd == CMD_WRITE) && ADDR_IN[`LCP_AC_BIT] // R21
        && (BANK_SEL_IN == 2'h0) && lq_q.open[0] && (cmd != CMD_ROW_OPEN)
        |-> ##[1:12] !lq_q.open[0])
        else $error("write auto close did not close bank");

    c_read_burst: cover property ((cmd == CMD_READ) ##4 DQ_OE_OUT ##1 DQ_OE_OUT);
    c_burst_stop: cover property (lq_q.rd_active && tap.stop);
    c_auto_close: cover property (lq_q.rd_active && (lq_q.rd_left == 4'h0) && lq_q.rd_ac);
endmodule : lcp_top

/* File: verif/lcp_ctrl_model.sv */
module lcp_ctrl_model #(
    parameter int CK_PS = 6000
) (
    // Link clock
    input wire logic ck_in,
    // Command pins, cmd is {cs_n, ras_n, cas_n, we_n}
    output logic cke_out,
    output logic [3:0] cmd_out,
    output logic [1:0] bank_out,
    output logic [12:0] addr_out
);
    timeunit 1ns;
    timeprecision 100ps;

    function automatic int cyc(input int ps);
        return (ps + CK_PS - 1) / CK_PS;
    endfunction : cyc

    initial begin
        cke_out = 1'b1;
        cmd_out = 4'hF;
        bank_out = 2'h0;
        addr_out = 13'h0000;
    end

    task automatic set_cke(input logic v);
        @(posedge ck_in);
        #1;
        cke_out = v;
    endtask : set_cke

    // Gaps are paid after the command, so callers never think about them
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        @(posedge ck_in);
        #1;
        cmd_out = c;
        bank_out = b;
        addr_out = a;
        @(posedge ck_in);
        #1;
        cmd_out = 4'h7;
        addr_out = ~a;
        case (c)
            4'h0: repeat (2) @(posedge ck_in);
            // Full open period also covers access delay and minimum open time
            4'h3: repeat (cyc(65000)) @(posedge ck_in);
            4'h2: repeat (cyc(22500)) @(posedge ck_in);
            default: ;
        endcase
    endtask : cmd
endmodule : lcp_ctrl_model

/* File: verif/lpddr_command_protocol_test.sv */
module lpddr_command_protocol_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic link_ck = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] clr = 8'h00;
    logic [3:0] open_q;
    logic [12:0] mode_q;
    logic [12:0] ext_q;
    logic [7:0] viol;
    logic [31:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    int num_errors = 0;
    int samples_checked = 0;
    // Mode word, bank, start column; last two rows wrap inside the block
    logic [24:0] rows [4] = '{{13'h0032, 2'h1, 10'h010}, {13'h0021, 2'h0, 10'h3FE},
        {13'h0033, 2'h3, 10'h00C}, {13'h0024, 2'h2, 10'h01A}};

    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #3 link_ck = ~link_ck;
    end

    lcp_top u_lcp_top (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .VIOL_CLEAR_IN(clr),
        .BANK_OPEN_OUT(open_q), .MODE_REG_OUT(mode_q), .EXT_MODE_OUT(ext_q),
        .VIOL_OUT(viol), .LINK_CK_IN(link_ck), .CKE_IN(cke), .CS_N_IN(cmd[3]),
        .RAS_N_IN(cmd[2]), .CAS_N_IN(cmd[1]), .WE_N_IN(cmd[0]), .BANK_SEL_IN(ba),
        .ADDR_IN(addr), .DQ_IN(32'h0000_0000), .DQ_OUT(dq), .DQ_OE_OUT(dq_oe),
        .DQS_IN(1'b0), .DQS_OUT(dqs), .DQS_OE_OUT(dqs_oe));
    lcp_ctrl_model u_lcp_ctrl_model (.ck_in(link_ck), .cke_out(cke), .cmd_out(cmd),
        .bank_out(ba), .addr_out(addr));

    task automatic results();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Entered just after the read's sampling edge
    task automatic burst(input logic [1:0] b, input logic [9:0] col, input int lat, input int n);
        logic [9:0] c;
        repeat (lat - 1) @(posedge link_ck);
        #1;
        check("preamble", 3'b100, {dqs_oe, dqs, dq_oe});
        for (int k = 0; k < n; k++) begin
            @(posedge link_ck);
            #1;
            c = (col & ~10'(2 * n - 1)) | ((col + 10'(2 * k)) & 10'(2 * n - 1));
            check("read pair", {b, 4'h0, c + 10'h1, b, 4'h0, c}, dq);
            check("strobe", 3'b111, {dqs_oe, dqs, dq_oe});
        end
        @(posedge link_ck);
        #1;
        check("release", 2'b00, {dqs_oe, dq_oe});
    endtask : burst

    // Status crosses clock domains, so allow it a bounded while to arrive
    task automatic settle(input logic [11:0] exp);
        int i = 0;
        // One snapshot may be in flight with stale state; let the next one land
        repeat (12) @(posedge sys_clk);
        while ({open_q, viol} !== exp && i < 40) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        check("status", exp, {open_q, viol});
        if (i == 40) results();
    endtask : settle

    initial begin
        logic [12:0] m;
        int lat;
        int n;
        repeat (12) @(posedge sys_clk);
        #1;
        check("reset mode", 13'h0032, mode_q);
        check("reset status", 32'h0, {open_q, viol, ext_q});
        rst_n = 1'b1;
        repeat (8) @(posedge link_ck);
        foreach (rows[i]) begin
            m = rows[i][24:12];
            lat = (m[6:4] == 3'h2) ? 2 : 3;
            n = 1 << (m[2:0] - 1);
            u_lcp_ctrl_model.cmd(4'h0, 2'h0, m);
            u_lcp_ctrl_model.cmd(4'h3, rows[i][11:10], 13'h0ABC);
            u_lcp_ctrl_model.cmd(4'h5, rows[i][11:10], {3'b001, rows[i][9:0]});
            burst(rows[i][11:10], rows[i][9:0], lat, n);
            settle(12'h000);
            check("mode word", m, mode_q);
        end
        u_lcp_ctrl_model.cmd(4'h3, 2'h1, 13'h0001);
        u_lcp_ctrl_model.cmd(4'hD, 2'h1, 13'h0000);
        repeat (4) @(posedge link_ck);
        #1;
        check("deselect", 2'b00, {dqs_oe, dq_oe});
        u_lcp_ctrl_model.cmd(4'h5, 2'h1, 13'h0000);
        // Stop with clock enable low is power-down, so the burst runs on
        fork
            burst(2'h1, 10'h000, 2, 8);
            begin
                u_lcp_ctrl_model.set_cke(1'b0);
                u_lcp_ctrl_model.cmd(4'h6, 2'h1, 13'h0000);
                u_lcp_ctrl_model.set_cke(1'b1);
            end
        join
        u_lcp_ctrl_model.cmd(4'h5, 2'h1, 13'h0000);
        fork
            burst(2'h1, 10'h000, 2, 2);
            u_lcp_ctrl_model.cmd(4'h6, 2'h0, 13'h0000);
        join
        u_lcp_ctrl_model.cmd(4'h2, 2'h1, 13'h0000);
        u_lcp_ctrl_model.cmd(4'h3, 2'h0, 13'h0002);
        u_lcp_ctrl_model.cmd(4'h3, 2'h2, 13'h0003);
        u_lcp_ctrl_model.cmd(4'h4, 2'h0, 13'h0400);
        settle(12'h400);
        u_lcp_ctrl_model.cmd(4'h2, 2'h3, 13'h0400);
        settle(12'h000);
        u_lcp_ctrl_model.cmd(4'h0, 2'h2, 13'h0020);
        u_lcp_ctrl_model.cmd(4'h5, 2'h3, 13'h0000);
        settle(12'h004);
        check("ext word", 13'h0020, ext_q);
        clr = 8'hFF;
        settle(12'h000);
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("reset again", {13'h0032, 13'h0000}, {mode_q, ext_q});
        results();
    end
endmodule : lpddr_command_protocol_test
